// *** core/sysmgmt_wake_core.sv ***
// System-management event status, ring wake status and lamp control behind APB
`timescale 1ns/1ps
`include "wake_params.svh"

// Behaviour
// RQ1 - The event status register shows watchdog in bit 0, UART three in bit 1, UART four in bit 2.
// RQ2 - Writing one to the watchdog status bit clears it and writing zero leaves it alone.
// RQ3 - Each event enable bit passes its source to the group line when one and blocks it when zero.
// RQ4 - A wake status bit sets on its ring event whatever the enables hold.
// RQ5 - Ring events are flagged even while the pin serves its alternate function.
// RQ6 - The wake output goes low only when source enable, source status and global enable are one.
// RQ7 - A disabled wake source is still recorded but never pulls the wake output.
// RQ8 - Reserved bits and the reserved slot read as zero.
// RQ9 - Lamp code 10 blinks at 0.5 Hz with 25 % on time and code 11 holds the lamp on.
// RQ10 - The block keeps running whatever configuration state the host is in.
// RQ11 - Any watchdog timeout, forced or natural, is the watchdog event.
// RQ12 - The group line is the OR of status AND enable, and status holds until cleared or reset.
module sysmgmt_wake_core #(
    parameter int HALF_STEP_CYCLES = `LAMP_HALF_STEP_CYC
) (
    input  wire logic        SYS_CLK,                 // 125 MHz system clock
    input  wire logic        RSTN,                    // Asynchronous reset, active low
    input  wire logic        PSEL,                    // APB select
    input  wire logic        PENABLE,                 // APB access phase
    input  wire logic        PWRITE,                  // APB direction, high for write
    input  wire logic [7:0]  PADDR,                   // APB byte address
    input  wire logic [31:0] PWDATA,                  // APB write data
    output logic      [31:0] PRDATA,                  // APB read data
    output logic             PREADY,                  // APB ready
    output logic             PSLVERR,                 // APB error on unmapped address
    input  wire logic        WATCHDOG_EVENT,          // Watchdog timeout pulse
    input  wire logic        UART_THREE_IRQ,          // UART three interrupt level
    input  wire logic        UART_FOUR_IRQ,           // UART four interrupt level
    input  wire logic        RING_INDICATOR_THREE_N,  // Ring pin three, active low
    input  wire logic        RING_INDICATOR_FOUR_N,   // Ring pin four, active low
    output logic             GROUP_SYSMGMT_IRQ_N,     // Group management line, active low
    output logic             WAKE_OUT_N,              // Wake request, active low
    output logic             SECOND_LAMP_CONTROL,     // Lamp drive, high is lit
    output logic             IRQ                      // Block interrupt, active high
);

    // ------------
    // Declarations
    // ------------
    wake_pkg::core_state_t st;
    wake_pkg::core_state_t next_st;
    wake_evt_if            evt ();

    logic [5:0] index;
    logic       setup;
    logic       access;
    logic       do_write;
    logic       hit;
    logic [7:0] read_val;
    logic       wr_lamp;
    logic       wr_smi_status;
    logic       wr_smi_enable;
    logic       wr_wake_status;
    logic       wr_wake_enable;
    logic       wr_irq_clear;
    logic       wr_irq_enable;
    logic       wr_wake_ctrl;
    logic [7:0] wbyte;
    logic [2:0] smi_sources;
    logic [2:0] irq_events;
    logic       clr_watchdog;
    logic [1:0] clr_wake;
    logic [2:0] clr_irq;

    // ------------
    // Submodules
    // ------------
    ring_edge_detect u_ring (
        .clk    (SYS_CLK),
        .rst_n  (RSTN),
        .ring_n ({RING_INDICATOR_FOUR_N, RING_INDICATOR_THREE_N}),
        .evt    (evt.detector)
    );

    lamp_blinker #(
        .HALF_STEP_CYCLES (HALF_STEP_CYCLES)
    ) u_lamp (
        .clk   (SYS_CLK),
        .rst_n (RSTN),
        .evt   (evt.lamp)
    );

    // ------------
    // Lamp code decode
    // ------------
    always_comb begin
        case (st.lamp_code)
            2'b01:   evt.lamp_mode = wake_pkg::LAMP_FAST;
            2'b10:   evt.lamp_mode = wake_pkg::LAMP_SLOW; // RQ9
            2'b11:   evt.lamp_mode = wake_pkg::LAMP_ON;   // RQ9
            default: evt.lamp_mode = wake_pkg::LAMP_OFF;
        endcase
    end

    // ------------
    // Address decode
    // ------------
    assign index    = PADDR[7:2];
    assign setup    = PSEL & ~PENABLE;
    assign access   = PSEL & PENABLE & st.pready;
    assign do_write = access & PWRITE;
    assign wbyte    = PWDATA[7:0];

    always_comb begin
        hit            = 1'b1;
        read_val       = `RESET_BYTE;
        wr_lamp        = 1'b0;
        wr_smi_status  = 1'b0;
        wr_smi_enable  = 1'b0;
        wr_wake_status = 1'b0;
        wr_wake_enable = 1'b0;
        wr_irq_clear   = 1'b0;
        wr_irq_enable  = 1'b0;
        wr_wake_ctrl   = 1'b0;
        if (index == `IDX_LAMP_CTRL) begin
            read_val = {6'b00_0000, st.lamp_code};
            wr_lamp  = do_write;
        end else if (index == `IDX_RSVD_ZERO) begin
            read_val = `RESET_BYTE; // RQ8
        end else if (index == `IDX_SMI_STATUS) begin
            read_val      = {5'b0_0000, smi_sources}; // RQ1
            wr_smi_status = do_write;
        end else if (index == `IDX_SMI_ENABLE) begin
            read_val      = {5'b0_0000, st.smi_enable}; // RQ8
            wr_smi_enable = do_write;
        end else if (index == `IDX_WAKE_STATUS) begin
            read_val       = {6'b00_0000, st.wake_status};
            wr_wake_status = do_write;
        end else if (index == `IDX_WAKE_ENABLE) begin
            read_val       = {6'b00_0000, st.wake_enable};
            wr_wake_enable = do_write;
        end else if (index == `IDX_IRQ_STATUS) begin
            read_val = {5'b0_0000, st.irq_status};
        end else if (index == `IDX_IRQ_CLEAR) begin
            // Write-only, so reads give zero
            read_val     = `RESET_BYTE;
            wr_irq_clear = do_write;
        end else if (index == `IDX_IRQ_ENABLE) begin
            read_val      = {5'b0_0000, st.irq_enable};
            wr_irq_enable = do_write;
        end else if (index == `IDX_WAKE_CTRL) begin
            read_val     = {7'b000_0000, st.global_wake_enable};
            wr_wake_ctrl = do_write;
        end else begin
            hit = 1'b0;
        end
    end

    // ------------
    // Event sources and clears
    // ------------
    // UART bits follow their source level; the UART itself clears them
    assign smi_sources = {UART_FOUR_IRQ, UART_THREE_IRQ, st.smi_watchdog}; // RQ1

    assign clr_watchdog = wr_smi_status & wbyte[`SMI_BIT_WATCHDOG]; // RQ2
    assign clr_wake     = wr_wake_status ? wbyte[1:0] : 2'b00;
    assign clr_irq      = wr_irq_clear ? wbyte[2:0] : 3'b000;

    assign irq_events = {evt.ring_fall[`WAKE_BIT_RING4],
                         evt.ring_fall[`WAKE_BIT_RING3],
                         WATCHDOG_EVENT};

    // ------------
    // Next state
    // ------------
    // Nothing here looks at any host configuration state, so it never stalls
    always_comb begin // RQ10
        next_st = st;

        // Bus answer: read data and ready in the cycle after setup
        next_st.pready  = setup;
        next_st.pslverr = setup & ~hit;
        next_st.prdata  = (setup & ~PWRITE) ? read_val : `RESET_BYTE;

        // Sticky watchdog bit; a set in the clearing cycle wins
        next_st.smi_watchdog = (st.smi_watchdog & ~clr_watchdog) | WATCHDOG_EVENT; // RQ11 RQ12

        // Ring status records regardless of any enable
        next_st.wake_status = (st.wake_status & ~clr_wake) | evt.ring_fall; // RQ4 RQ7

        next_st.irq_status = (st.irq_status & ~clr_irq) | irq_events;

        if (wr_lamp) begin
            next_st.lamp_code = wbyte[1:0];
        end
        if (wr_smi_enable) begin
            next_st.smi_enable = wbyte[2:0];
        end
        if (wr_wake_enable) begin
            next_st.wake_enable = wbyte[1:0];
        end
        if (wr_irq_enable) begin
            next_st.irq_enable = wbyte[2:0];
        end
        if (wr_wake_ctrl) begin
            next_st.global_wake_enable = wbyte[`CTRL_BIT_GLOBAL];
        end

        // Outputs settle one cycle after the status they follow
        next_st.smi_n  = ~|(smi_sources & st.smi_enable); // RQ3 RQ12
        next_st.wake_n = ~(st.global_wake_enable
                           & |(st.wake_status & st.wake_enable)); // RQ6 RQ7
        next_st.irq    = |(st.irq_status & st.irq_enable);
    end

    // ------------
    // State register
    // ------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '{prdata:             `RESET_BYTE,
                    pready:             1'b0,
                    pslverr:            1'b0,
                    smi_watchdog:       1'b0,
                    lamp_code:          2'b00,
                    smi_enable:         3'b000,
                    wake_status:        2'b00,
                    wake_enable:        2'b00,
                    global_wake_enable: 1'b0,
                    irq_status:         3'b000,
                    irq_enable:         3'b000,
                    smi_n:              1'b1,
                    wake_n:             1'b1,
                    irq:                1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------
    // Outputs
    // ------------
    assign PRDATA              = {`READ_ZERO_HI, st.prdata}; // RQ8
    assign PREADY              = st.pready;
    assign PSLVERR             = st.pslverr;
    assign GROUP_SYSMGMT_IRQ_N = st.smi_n;
    assign WAKE_OUT_N          = st.wake_n;
    assign SECOND_LAMP_CONTROL = evt.lamp_on;
    assign IRQ                 = st.irq;

endmodule : sysmgmt_wake_core

// *** core/wake_params.svh ***
// Register indices, field positions, reset values and timing figures of the wake block
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH

// ------------
// Register indices (byte address = 4 * index)
// ------------
`define IDX_LAMP_CTRL     6'h16
`define IDX_RSVD_ZERO     6'h17
`define IDX_SMI_STATUS    6'h18
`define IDX_SMI_ENABLE    6'h19
`define IDX_WAKE_STATUS   6'h1A
`define IDX_WAKE_ENABLE   6'h1B
`define IDX_IRQ_STATUS    6'h1C
`define IDX_IRQ_CLEAR     6'h1D
`define IDX_IRQ_ENABLE    6'h1E
`define IDX_WAKE_CTRL     6'h1F

// ------------
// Field positions
// ------------
`define SMI_BIT_WATCHDOG  0
`define SMI_BIT_UART3     1
`define SMI_BIT_UART4     2
`define WAKE_BIT_RING3    0
`define WAKE_BIT_RING4    1
`define CTRL_BIT_GLOBAL   0
`define IRQ_BIT_WATCHDOG  0
`define IRQ_BIT_RING3     1
`define IRQ_BIT_RING4     2

// ------------
// Reset values
// ------------
`define RESET_BYTE        8'h00
`define READ_ZERO_HI      24'h00_0000

// ------------
// Timing
// ------------
`define SYS_CLK_KHZ        125000
`define LAMP_HALF_STEP_MS  500
`define LAMP_HALF_STEP_CYC (`LAMP_HALF_STEP_MS * `SYS_CLK_KHZ)

`endif

// *** core/wake_pkg.sv ***
// Types shared by the wake and system-management event block
package wake_pkg;

    typedef enum logic [3:0] {
        LAMP_OFF   = 4'b0001,
        LAMP_FAST  = 4'b0010,
        LAMP_SLOW  = 4'b0100,
        LAMP_ON    = 4'b1000
    } lamp_mode_t;

    typedef enum logic [2:0] {
        BUS_IDLE   = 3'b001,
        BUS_SETUP  = 3'b010,
        BUS_ACCESS = 3'b100
    } bus_phase_t;

    typedef struct packed {
        logic [7:0] prdata;
        logic       pready;
        logic       pslverr;
        logic       smi_watchdog;
        logic [1:0] lamp_code;
        logic [2:0] smi_enable;
        logic [1:0] wake_status;
        logic [1:0] wake_enable;
        logic       global_wake_enable;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic       smi_n;
        logic       wake_n;
        logic       irq;
    } core_state_t;

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
        logic [1:0] prev;
    } ring_state_t;

    typedef struct packed {
        logic [31:0] count;
        logic [1:0]  phase;
        lamp_mode_t  mode;
        logic        lamp_on;
    } lamp_state_t;

endpackage : wake_pkg

// *** core/wake_evt_if.sv ***
// Carrier between the wake core, the ring pin detector and the lamp driver
`timescale 1ns/1ps
interface wake_evt_if;
    logic [1:0]           ring_fall;   // One-cycle pulse per falling ring edge
    wake_pkg::lamp_mode_t lamp_mode;   // Decoded lamp mode
    logic                 lamp_on;     // Lamp level from the driver

    modport detector (output ring_fall);
    modport lamp     (input lamp_mode, output lamp_on);
    modport core     (input ring_fall, input lamp_on, output lamp_mode);
endinterface : wake_evt_if

// *** core/ring_edge_detect.sv ***
// Two-stage synchroniser and falling-edge detector for the ring indicator pins
`timescale 1ns/1ps
`include "wake_params.svh"
module ring_edge_detect (
    input  wire logic       clk,        // System clock
    input  wire logic       rst_n,      // Asynchronous reset, active low
    input  wire logic [1:0] ring_n,     // Raw ring pins, active low
    wake_evt_if.detector    evt         // Edge pulses out
);
    wake_pkg::ring_state_t st;
    wake_pkg::ring_state_t next_st;

    // Idle pins are high, so the history starts high to avoid a false edge
    always_comb begin
        next_st        = st;
        next_st.stage1 = ring_n;
        next_st.stage2 = st.stage1;
        next_st.prev   = st.stage2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {2'b11, 2'b11, 2'b11};
        end else begin
            st <= next_st;
        end
    end

    // Pin function select is not looked at: alternate use still flags events
    assign evt.ring_fall = st.prev & ~st.stage2; // RQ5
endmodule : ring_edge_detect

// *** core/lamp_blinker.sv ***
// Lamp driver: off, 1 Hz 50 %, 0.5 Hz 25 % and steady on
`timescale 1ns/1ps
`include "wake_params.svh"
module lamp_blinker #(
    parameter int HALF_STEP_CYCLES = `LAMP_HALF_STEP_CYC
) (
    input  wire logic clk,     // System clock
    input  wire logic rst_n,   // Asynchronous reset, active low
    wake_evt_if.lamp  evt      // Mode in, lamp level out
);
    wake_pkg::lamp_state_t st;
    wake_pkg::lamp_state_t next_st;
    logic                  step;

    // ------------
    // Half-second step and four-step phase
    // ------------
    always_comb begin
        next_st      = st;
        step         = (st.count == 32'(HALF_STEP_CYCLES - 1));
        next_st.mode = evt.lamp_mode;
        if (st.mode != evt.lamp_mode) begin
            // Restart the pattern so a new mode begins with a full on time
            next_st.count = 32'h0000_0000;
            next_st.phase = 2'b00;
        end else if (step) begin
            next_st.count = 32'h0000_0000;
            next_st.phase = st.phase + 2'b01;
        end else begin
            next_st.count = st.count + 32'h0000_0001;
        end
        case (st.mode)
            wake_pkg::LAMP_FAST: next_st.lamp_on = ~st.phase[0];
            wake_pkg::LAMP_SLOW: next_st.lamp_on = (st.phase == 2'b00); // RQ9
            wake_pkg::LAMP_ON:   next_st.lamp_on = 1'b1;                // RQ9
            default:             next_st.lamp_on = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {32'h0000_0000, 2'b00, wake_pkg::LAMP_OFF, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign evt.lamp_on = st.lamp_on;
endmodule : lamp_blinker

// *** sim/wake_chk.sv ***
// Port-level assertions for the wake and management event core
`timescale 1ns/1ps
`include "wake_params.svh"
module wake_chk (
    input wire logic        SYS_CLK, // Clock
    input wire logic        RSTN, // Reset, active low
    input wire logic        PSEL, // APB select
    input wire logic        PENABLE, // APB access
    input wire logic        PWRITE, // APB write
    input wire logic [7:0]  PADDR, // APB address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic [31:0] PRDATA, // APB read data
    input wire logic        PREADY, // APB ready
    input wire logic        PSLVERR, // APB error
    input wire logic        WATCHDOG_EVENT, // Watchdog pulse
    input wire logic        UART_THREE_IRQ, // UART three level
    input wire logic        UART_FOUR_IRQ, // UART four level
    input wire logic        RING_INDICATOR_THREE_N, // Ring pin three
    input wire logic        GROUP_SYSMGMT_IRQ_N, // Management line
    input wire logic        WAKE_OUT_N, // Wake line
    input wire logic        IRQ // Block interrupt
);
    // ------------
    // Shadow of the enable registers
    // ------------
    logic       wr;
    logic [5:0] idx;
    logic [2:0] smi_en;
    logic [2:0] irq_en;
    logic [1:0] wk_en;
    logic       gwe;
    assign wr  = PSEL & PENABLE & PREADY & PWRITE;
    assign idx = PADDR[7:2];
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            smi_en <= 3'h0;
            irq_en <= 3'h0;
            wk_en  <= 2'h0;
            gwe    <= 1'b0;
        end else if (wr) begin
            if (idx == `IDX_SMI_ENABLE) smi_en <= PWDATA[2:0];
            if (idx == `IDX_IRQ_ENABLE) irq_en <= PWDATA[2:0];
            if (idx == `IDX_WAKE_ENABLE) wk_en <= PWDATA[1:0];
            if (idx == `IDX_WAKE_CTRL) gwe <= PWDATA[0];
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    ready_pulse_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("Ready is not one cycle after setup");
    slverr_map_a: assert property (PSEL && !PENABLE |=> PSLVERR ==
        ($past(idx) < `IDX_LAMP_CTRL || $past(idx) > `IDX_WAKE_CTRL))
        else $error("Error flag does not match the address map");
    read_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000
        && (idx != `IDX_RSVD_ZERO || PRDATA[7:0] == 8'h00)
        && (idx != `IDX_SMI_STATUS || PRDATA[7:3] == 5'h00))
        else $error("Reserved read bits not zero");
    uart_route_a: assert property ($past(UART_THREE_IRQ) && $past(smi_en[1])
        |-> !GROUP_SYSMGMT_IRQ_N) else $error("Enabled UART three not on management line");
    smi_cause_a: assert property (!GROUP_SYSMGMT_IRQ_N |-> $past(smi_en[0])
        || $past(smi_en[1] && UART_THREE_IRQ) || $past(smi_en[2] && UART_FOUR_IRQ))
        else $error("Management line low without enabled cause");
    wdog_smi_a: assert property ((WATCHDOG_EVENT && smi_en[0]) ##1 (smi_en[0] && !wr)
        |=> !GROUP_SYSMGMT_IRQ_N) else $error("Watchdog event missed the management line");
    wake_gate_a: assert property (!WAKE_OUT_N |-> $past(gwe) && $past(wk_en) != 2'h0)
        else $error("Wake line low without enables");
    ring_wake_a: assert property ($fell(RING_INDICATOR_THREE_N) && wk_en[0] && gwe
        |-> ##[2:8] !WAKE_OUT_N) else $error("Ring three event did not wake");
    irq_level_a: assert property (WATCHDOG_EVENT && irq_en[0] |-> ##2 IRQ)
        else $error("Interrupt not raised by watchdog event");
endmodule : wake_chk

bind sysmgmt_wake_core wake_chk u_chk (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WATCHDOG_EVENT(WATCHDOG_EVENT), .UART_THREE_IRQ(UART_THREE_IRQ),
    .UART_FOUR_IRQ(UART_FOUR_IRQ), .RING_INDICATOR_THREE_N(RING_INDICATOR_THREE_N),
    .GROUP_SYSMGMT_IRQ_N(GROUP_SYSMGMT_IRQ_N), .WAKE_OUT_N(WAKE_OUT_N), .IRQ(IRQ)
);

// *** sim/host_wake_rx.sv ***
// Host-side receiver that counts wake requests
`timescale 1ns/1ps
module host_wake_rx (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic wake_n, // Wake request line
    output int       n_wake // Wake requests seen
);
    logic wake_d;
    // Counts falling edges only, so a held request is one wake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_d <= 1'b1;
            n_wake <= 0;
        end else begin
            wake_d <= wake_n;
            if (wake_d && !wake_n) n_wake <= n_wake + 1;
        end
    end
endmodule : host_wake_rx

// *** sim/sysmgmt_wake_core_tb.sv ***
// Self-checking bench for the wake and management event core
`timescale 1ns/1ps
`include "wake_params.svh"
module sysmgmt_wake_core_tb;
    logic        SYS_CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
    logic        WATCHDOG_EVENT, UART_THREE_IRQ, UART_FOUR_IRQ, WAKE_OUT_N;
    logic        RING_INDICATOR_THREE_N, RING_INDICATOR_FOUR_N;
    logic        GROUP_SYSMGMT_IRQ_N, SECOND_LAMP_CONTROL;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    int          n_wake;
    int          n_errors = 0;
    int          checks = 0;

    sysmgmt_wake_core #(.HALF_STEP_CYCLES(4)) DUT (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WATCHDOG_EVENT(WATCHDOG_EVENT),
        .UART_THREE_IRQ(UART_THREE_IRQ), .UART_FOUR_IRQ(UART_FOUR_IRQ),
        .RING_INDICATOR_THREE_N(RING_INDICATOR_THREE_N),
        .RING_INDICATOR_FOUR_N(RING_INDICATOR_FOUR_N), .GROUP_SYSMGMT_IRQ_N(GROUP_SYSMGMT_IRQ_N),
        .WAKE_OUT_N(WAKE_OUT_N), .SECOND_LAMP_CONTROL(SECOND_LAMP_CONTROL), .IRQ(IRQ));
    host_wake_rx u_host (.clk(SYS_CLK), .rst_n(RSTN), .wake_n(WAKE_OUT_N), .n_wake(n_wake));

    task automatic final_report();
        $display("Mismatches %0d of %0d checks", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic pin(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask : pin

    // ------------
    // APB master: request held until ready is sampled
    // ------------
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= {idx, 2'b00};
        PWDATA  <= {24'h00_0000, wd};
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(what, {24'h00_0000, exp}, r);
    endtask : rd

    task automatic pulse_wdog();
        @(posedge SYS_CLK);
        WATCHDOG_EVENT <= 1'b1;
        @(posedge SYS_CLK);
        WATCHDOG_EVENT <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
    endtask : pulse_wdog

    task automatic ring(input int k);
        @(posedge SYS_CLK);
        if (k == 0) RING_INDICATOR_THREE_N <= 1'b0;
        else RING_INDICATOR_FOUR_N <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        RING_INDICATOR_THREE_N <= 1'b1;
        RING_INDICATOR_FOUR_N  <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
    endtask : ring

    // ------------
    // Scenarios
    // ------------
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        for (int i = `IDX_LAMP_CTRL; i <= `IDX_WAKE_CTRL; i++) rd(i[5:0], 8'h00, "reset value");
        apb(1'b0, 6'h05, 8'h00, r, e);
        pin("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0000_0000, r);
        wr(`IDX_RSVD_ZERO, 8'hFF);
        rd(`IDX_RSVD_ZERO, 8'h00, "reserved slot");
        wr(`IDX_SMI_ENABLE, 8'hFF);
        rd(`IDX_SMI_ENABLE, 8'h07, "enable reserved bits");
        wr(`IDX_SMI_ENABLE, 8'h00);
    endtask : t_regs

    task automatic t_wdog();
        wr(`IDX_SMI_ENABLE, 8'h01);
        pulse_wdog();
        pin("smi line low", 1'b0, GROUP_SYSMGMT_IRQ_N);
        pin("irq masked", 1'b0, IRQ);
        rd(`IDX_SMI_STATUS, 8'h01, "watchdog status");
        rd(`IDX_IRQ_STATUS, 8'h01, "irq status");
        wr(`IDX_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge SYS_CLK);
        pin("irq raised", 1'b1, IRQ);
        wr(`IDX_IRQ_CLEAR, 8'h01);
        rd(`IDX_IRQ_STATUS, 8'h00, "irq cleared");
        pin("irq dropped", 1'b0, IRQ);
        wr(`IDX_SMI_STATUS, 8'h00);
        rd(`IDX_SMI_STATUS, 8'h01, "status kept on zero");
        wr(`IDX_SMI_STATUS, 8'h01);
        rd(`IDX_SMI_STATUS, 8'h00, "status cleared on one");
        pin("smi line released", 1'b1, GROUP_SYSMGMT_IRQ_N);
        wr(`IDX_SMI_ENABLE, 8'h00);
        pulse_wdog();
        pin("smi blocked", 1'b1, GROUP_SYSMGMT_IRQ_N);
        pin("irq from second event", 1'b1, IRQ);
        rd(`IDX_SMI_STATUS, 8'h01, "status without enable");
        wr(`IDX_SMI_STATUS, 8'h01);
        wr(`IDX_IRQ_CLEAR, 8'h01);
    endtask : t_wdog

    task automatic t_uart();
        @(posedge SYS_CLK);
        UART_THREE_IRQ <= 1'b1;
        UART_FOUR_IRQ  <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        rd(`IDX_SMI_STATUS, 8'h06, "uart levels");
        pin("uarts blocked", 1'b1, GROUP_SYSMGMT_IRQ_N);
        wr(`IDX_SMI_ENABLE, 8'h04);
        repeat (2) @(posedge SYS_CLK);
        pin("uart four routed", 1'b0, GROUP_SYSMGMT_IRQ_N);
        UART_FOUR_IRQ <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        pin("uart four gone", 1'b1, GROUP_SYSMGMT_IRQ_N);
        wr(`IDX_SMI_ENABLE, 8'h02);
        repeat (2) @(posedge SYS_CLK);
        pin("uart three routed", 1'b0, GROUP_SYSMGMT_IRQ_N);
        UART_THREE_IRQ <= 1'b0;
        wr(`IDX_SMI_ENABLE, 8'h00);
    endtask : t_uart

    task automatic t_wake();
        wr(`IDX_WAKE_CTRL, 8'h01);
        ring(0);
        rd(`IDX_WAKE_STATUS, 8'h01, "ring three recorded");
        pin("wake held off", 1'b1, WAKE_OUT_N);
        wr(`IDX_WAKE_ENABLE, 8'h01);
        repeat (2) @(posedge SYS_CLK);
        pin("wake asserted", 1'b0, WAKE_OUT_N);
        wr(`IDX_WAKE_CTRL, 8'h00);
        repeat (2) @(posedge SYS_CLK);
        pin("global gate", 1'b1, WAKE_OUT_N);
        wr(`IDX_WAKE_STATUS, 8'h01);
        wr(`IDX_WAKE_CTRL, 8'h01);
        rd(`IDX_WAKE_STATUS, 8'h00, "wake cleared");
        ring(0);
        chk("host wake count", 32'h0000_0002, n_wake);
        wr(`IDX_WAKE_STATUS, 8'h01);
        ring(1);
        rd(`IDX_WAKE_STATUS, 8'h02, "ring four recorded");
        pin("ring four disabled", 1'b1, WAKE_OUT_N);
        wr(`IDX_WAKE_STATUS, 8'h02);
    endtask : t_wake

    task automatic t_lamp();
        logic [31:0] on;
        int exp[4] = '{0, 16, 8, 32};
        // 32 cycles is whole periods for every mode at half step 4
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_LAMP_CTRL, c[7:0]);
            repeat (3) @(posedge SYS_CLK);
            on = 0;
            repeat (32) begin
                @(posedge SYS_CLK);
                on += {31'h0, SECOND_LAMP_CONTROL};
            end
            chk("lamp lit cycles", exp[c], on);
        end
    endtask : t_lamp

    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        n_errors++;
        final_report();
    end

    initial begin
        {RSTN, PSEL, PENABLE, PWRITE, WATCHDOG_EVENT, UART_THREE_IRQ, UART_FOUR_IRQ} = 7'h00;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        RING_INDICATOR_THREE_N = 1'b1;
        RING_INDICATOR_FOUR_N = 1'b1;
        repeat (20) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        t_regs();
        t_wdog();
        t_uart();
        t_wake();
        t_lamp();
        final_report();
    end
endmodule : sysmgmt_wake_core_tb
